// ### core/fcpwm_top.sv
// five channel pulse width modulator with an axi4-lite register slave
// assumes one clock aclk with synchronous active low reset aresetn;
// port i/o logic outside supplies the general purpose levels for the pins
module fcpwm_top
  import fcpwm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [4:0] gpio_level,
  output logic [4:0] port1_pin_q,
  output logic [4:0] port1_pwm_sel_q
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0] modulator_control_first_q;
  logic [7:0] modulator_control_second_q;
  logic [7:0] period_prescaler_value_q;
  logic [7:0] duty_q [FCPWM_NCH];
  logic [7:0] presc_cnt_q;
  logic [7:0] count_q;

  // ****************************************************************
  // bus handshake state
  // ****************************************************************
  logic awready_q;
  logic wready_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  fcpwm_wr_s wr;
  logic wr_fire;
  logic wr_hit;
  logic [7:0] wr_word;
  logic [7:0] rd_word;
  logic [7:0] duty_idx_w;
  logic [7:0] duty_idx_r;

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // ****************************************************************
  // write address and data capture
  // ****************************************************************
  // address and data are taken in either order; each ready drops once
  // its item is held and rises again only after the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_got_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end else if (bvalid_q && bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_got_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end else if (wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_got_q <= 1'b1;
      w_data_q <= wdata[7:0];
      w_strb_q <= wstrb[0];
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end else if (bvalid_q && bready) begin
      wready_q <= 1'b1;
    end
  end

  // ****************************************************************
  // write decode
  // ****************************************************************
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign wr = '{addr: aw_addr_q & FCPWM_WORD_MASK, data: w_data_q, strb: w_strb_q};
  assign wr_word = wr.addr;
  assign duty_idx_w = (wr_word - FCPWM_OFS_DUTY0) >> FCPWM_WORD_SHIFT;

  // the counter word is read only; writing it is accepted and dropped
  always_comb begin
    wr_hit = 1'b0;
    if (wr_word == FCPWM_OFS_CTRL1) begin
      wr_hit = 1'b1;
    end else if (wr_word == FCPWM_OFS_CTRL2) begin
      wr_hit = 1'b1;
    end else if (wr_word == FCPWM_OFS_PRESC) begin
      wr_hit = 1'b1;
    end else if (wr_word >= FCPWM_OFS_DUTY0 && wr_word <= FCPWM_OFS_DUTY4) begin
      wr_hit = 1'b1;
    end else if (wr_word == FCPWM_OFS_COUNT) begin
      wr_hit = 1'b1;
    end
  end

  // write response, held until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= FCPWM_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? FCPWM_RESP_OKAY : FCPWM_RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // only byte lane 0 carries register bits; other lanes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modulator_control_first_q <= FCPWM_CTRL1_RST;
    end else if (wr_fire && wr.strb && wr_word == FCPWM_OFS_CTRL1) begin
      modulator_control_first_q <= wr.data;
    end
  end

  // unassigned bits of the second control word are not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modulator_control_second_q <= FCPWM_CTRL2_RST;
    end else if (wr_fire && wr.strb && wr_word == FCPWM_OFS_CTRL2) begin
      modulator_control_second_q <= wr.data & FCPWM_CTRL2_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_prescaler_value_q <= FCPWM_PRESC_RST;
    end else if (wr_fire && wr.strb && wr_word == FCPWM_OFS_PRESC) begin
      period_prescaler_value_q <= wr.data;
    end
  end

  // duty words sit at consecutive aligned addresses, one per channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < FCPWM_NCH; i++) begin
        duty_q[i] <= FCPWM_DUTY_RST;
      end
    end else if (wr_fire && wr.strb && wr_word >= FCPWM_OFS_DUTY0 &&
                 wr_word <= FCPWM_OFS_DUTY4) begin
      duty_q[duty_idx_w[2:0]] <= wr.data;
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  assign rd_word = araddr & FCPWM_WORD_MASK;
  assign duty_idx_r = (rd_word - FCPWM_OFS_DUTY0) >> FCPWM_WORD_SHIFT;

  // data is sampled at the address handshake, answered on that same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= FCPWM_RDATA_ZERO;
      rresp_q <= FCPWM_RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= FCPWM_RESP_OKAY;
      if (rd_word == FCPWM_OFS_CTRL1) begin
        rdata_q <= {FCPWM_RDATA_PAD, modulator_control_first_q};
      end else if (rd_word == FCPWM_OFS_CTRL2) begin
        rdata_q <= {FCPWM_RDATA_PAD, modulator_control_second_q};
      end else if (rd_word == FCPWM_OFS_PRESC) begin
        rdata_q <= {FCPWM_RDATA_PAD, period_prescaler_value_q};
      end else if (rd_word >= FCPWM_OFS_DUTY0 && rd_word <= FCPWM_OFS_DUTY4) begin
        rdata_q <= {FCPWM_RDATA_PAD, duty_q[duty_idx_r[2:0]]};
      end else if (rd_word == FCPWM_OFS_COUNT) begin
        rdata_q <= {FCPWM_RDATA_PAD, count_q};
      end else begin
        rdata_q <= FCPWM_RDATA_ZERO;
        rresp_q <= FCPWM_RESP_SLVERR;
      end
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ****************************************************************
  // shared time base
  // ****************************************************************
  logic any_run;
  logic tick;
  fcpwm_chan_cfg_s cfg [FCPWM_NCH];

  // the time base halts and clears when no channel runs, so the first
  // period after an enable with all channels stopped starts from counter zero
  assign any_run = cfg[0].run | cfg[1].run | cfg[2].run | cfg[3].run | cfg[4].run;
  // at or above, so lowering the prescaler mid-count cannot run it past
  // the new value and round the full 8-bit range before the next tick
  assign tick = (presc_cnt_q >= period_prescaler_value_q);

  // prescaler: one tick every value plus one clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_cnt_q <= FCPWM_COUNT_RST;
    end else if (!any_run || tick) begin
      presc_cnt_q <= FCPWM_COUNT_RST;
    end else begin
      presc_cnt_q <= presc_cnt_q + FCPWM_COUNT_STEP;
    end
  end

  // period counter wraps naturally at its 8-bit width
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= FCPWM_COUNT_RST;
    end else if (!any_run) begin
      count_q <= FCPWM_COUNT_RST;
    end else if (tick) begin
      count_q <= count_q + FCPWM_COUNT_STEP;
    end
  end

  // ****************************************************************
  // channel configuration and instances
  // ****************************************************************
  // channels 0 to 3 from the first control word, channel 4 from the second
  generate
    for (genvar c = 0; c < FCPWM_CH4; c++) begin : g_cfg
      assign cfg[c] = '{run: modulator_control_first_q[FCPWM_RUN_POS[c]],
                        pin: modulator_control_first_q[FCPWM_PIN_POS[c]],
                        duty: duty_q[c]};
    end
  endgenerate

  assign cfg[FCPWM_CH4] = '{run: modulator_control_second_q[FCPWM_CH4_RUN_POS],
                            pin: modulator_control_second_q[FCPWM_CH4_PIN_POS],
                            duty: duty_q[FCPWM_CH4]};

  // channel c drives port-1 bit c directly; the pin base is not used
  generate
    for (genvar c = 0; c < FCPWM_NCH; c++) begin : g_ch
      fcpwm_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg[c]),
        .count(count_q),
        .gpio_level(gpio_level[c]),
        .pin_q(port1_pin_q[c]),
        .pwm_sel_q(port1_pwm_sel_q[c])
      );
    end
  endgenerate

endmodule

// ### core/fcpwm_pkg.sv
// constants, register map and carrier types for the five channel modulator
// assumes a single aclk domain and an axi4-lite master that keeps to its protocol
package fcpwm_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int FCPWM_NCH = 5;
  localparam int FCPWM_ADDR_W = 8;
  localparam int FCPWM_DATA_W = 32;
  localparam int FCPWM_REG_W = 8;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [7:0] FCPWM_OFS_CTRL1 = 8'h00;
  localparam logic [7:0] FCPWM_OFS_CTRL2 = 8'h04;
  localparam logic [7:0] FCPWM_OFS_PRESC = 8'h08;
  localparam logic [7:0] FCPWM_OFS_DUTY0 = 8'h0c;
  localparam logic [7:0] FCPWM_OFS_DUTY4 = 8'h1c;
  localparam logic [7:0] FCPWM_OFS_COUNT = 8'h20;
  localparam logic [7:0] FCPWM_WORD_MASK = 8'hfc;
  localparam int FCPWM_WORD_SHIFT = 2;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int FCPWM_RUN_POS [4] = '{0, 1, 4, 5};
  localparam int FCPWM_PIN_POS [4] = '{2, 3, 6, 7};
  localparam int FCPWM_CH4 = 4;
  localparam int FCPWM_CH4_RUN_POS = 0;
  localparam int FCPWM_CH4_PIN_POS = 2;
  localparam int FCPWM_PIN_BASE = 3;
  localparam logic [7:0] FCPWM_CTRL2_MASK = 8'h05;

  // ****************************************************************
  // reset values and counter step
  // ****************************************************************
  localparam logic [7:0] FCPWM_CTRL1_RST = 8'h00;
  localparam logic [7:0] FCPWM_CTRL2_RST = 8'h00;
  localparam logic [7:0] FCPWM_PRESC_RST = 8'h00;
  localparam logic [7:0] FCPWM_DUTY_RST = 8'h00;
  localparam logic [7:0] FCPWM_COUNT_RST = 8'h00;
  localparam logic [7:0] FCPWM_COUNT_STEP = 8'h01;

  // ****************************************************************
  // bus answers
  // ****************************************************************
  localparam logic [1:0] FCPWM_RESP_OKAY = 2'h0;
  localparam logic [1:0] FCPWM_RESP_SLVERR = 2'h2;
  localparam logic [31:0] FCPWM_RDATA_ZERO = 32'h0000_0000;
  localparam logic [23:0] FCPWM_RDATA_PAD = 24'h00_0000;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic run;
    logic pin;
    logic [7:0] duty;
  } fcpwm_chan_cfg_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic strb;
  } fcpwm_wr_s;

endpackage

// ### core/fcpwm_channel.sv
// one modulator channel: compare against the shared counter, then pin select
// assumes the counter and configuration come from the same aclk domain
module fcpwm_channel
  import fcpwm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire fcpwm_chan_cfg_s cfg,
  input wire logic [7:0] count,
  input wire logic gpio_level,
  output logic pin_q,
  output logic pwm_sel_q
);

  // ****************************************************************
  // waveform
  // ****************************************************************
  logic wave;

  // a stopped channel idles low so a later pin hand-over starts clean
  always_comb begin
    wave = 1'b0;
    if (cfg.run) begin
      wave = (cfg.duty > count);
    end
  end

  // pin level registered, so the pin never sees compare glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
      pwm_sel_q <= 1'b0;
    end else begin
      pin_q <= cfg.pin ? wave : gpio_level;
      pwm_sel_q <= cfg.pin;
    end
  end

endmodule

// ### tb/fcpwm_asserts.sv
// checker for the five channel modulator, watching top level ports only
// assumes single aclk domain, synchronous active low aresetn
module fcpwm_asserts
  import fcpwm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [4:0] gpio_level,
  input wire logic [4:0] port1_pin_q,
  input wire logic [4:0] port1_pwm_sel_q
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // reset must clear answers and pins, so it cannot be disabled by itself
  chk_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
    !bvalid && !rvalid && port1_pin_q == 5'h00 && port1_pwm_sel_q == 5'h00)
    else $error("reset left an output active");
  chk_write_answer: assert property (awvalid && awready && wvalid && wready
    |-> ##[1:2] bvalid) else $error("write not answered");
  chk_read_answer: assert property (arvalid && arready
    |=> rvalid && rdata[31:8] == 24'h00_0000) else $error("read answer wrong");
  chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  chk_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped early");
  chk_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  chk_read_busy: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  // compared only in cycles where no pin selection changed, to skip switch over
  chk_gpio_pass: assert property ($past(aresetn) && $stable(port1_pwm_sel_q)
    |-> ((~port1_pwm_sel_q) & (port1_pin_q ^ $past(gpio_level))) == 5'h00)
    else $error("unselected pin not following gpio");
  cov_write: cover property (bvalid && bready);
  cov_read: cover property (rvalid && rready);
  cov_all_sel: cover property (port1_pwm_sel_q == 5'h1f);
endmodule

bind fcpwm_top fcpwm_asserts i_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .gpio_level(gpio_level), .port1_pin_q(port1_pin_q),
  .port1_pwm_sel_q(port1_pwm_sel_q));

// ### tb/fcpwm_port_model.sv
// external side of the five port-1 pins: port latch levels and a load
// that counts how many clocks each pin spends high; assumes aclk domain
module fcpwm_port_model
  import fcpwm_pkg::*;
(
  input wire logic aclk,
  input wire logic [4:0] drive_pattern,
  input wire logic [4:0] pin_level,
  input wire logic count_clr,
  output logic [4:0] gpio_level,
  output logic [9:0] hi_cnt [FCPWM_NCH]
);
  // ****************************************************************
  // load
  // ****************************************************************
  // port latch levels offered to the pins when not modulating
  assign gpio_level = drive_pattern;
  // high time per pin, wide enough for one full 512 clock period
  always_ff @(posedge aclk) begin
    for (int c = 0; c < FCPWM_NCH; c++) begin
      hi_cnt[c] <= count_clr ? 10'h000 : hi_cnt[c] + {9'h000, pin_level[c]};
    end
  end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the five channel modulator
// assumes the axi4-lite map of fcpwm_pkg and one 200 MHz clock
module tb_top
  import fcpwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [7:0] a; logic [3:0] s; logic [31:0] d; logic [1:0] br; logic [31:0] rd;
    logic [1:0] rr;
  } fcpwm_row_s;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, clr = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rsp;
  logic [4:0] gpio, pins, sel, pattern = 5'h15;
  logic [9:0] hi [FCPWM_NCH];
  int n_errors = 0, num_checks = 0;
  fcpwm_row_s rows [8] = '{
    '{FCPWM_OFS_COUNT, 4'hf, 32'h33, FCPWM_RESP_OKAY, 32'h00, FCPWM_RESP_OKAY},
    '{FCPWM_OFS_CTRL1, 4'hf, 32'ha5, FCPWM_RESP_OKAY, 32'ha5, FCPWM_RESP_OKAY},
    '{FCPWM_OFS_CTRL2, 4'hf, 32'hff, FCPWM_RESP_OKAY, 32'h05, FCPWM_RESP_OKAY},
    '{FCPWM_OFS_PRESC, 4'hf, 32'h103, FCPWM_RESP_OKAY, 32'h03, FCPWM_RESP_OKAY},
    '{FCPWM_OFS_DUTY0, 4'hf, 32'h5a, FCPWM_RESP_OKAY, 32'h5a, FCPWM_RESP_OKAY},
    '{FCPWM_OFS_DUTY4, 4'hf, 32'hc3, FCPWM_RESP_OKAY, 32'hc3, FCPWM_RESP_OKAY},
    '{8'h10, 4'h0, 32'h77, FCPWM_RESP_OKAY, 32'h00, FCPWM_RESP_OKAY},
    '{8'h40, 4'hf, 32'h11, FCPWM_RESP_SLVERR, 32'h00, FCPWM_RESP_SLVERR}};

  always #2.5 aclk = ~aclk;

  fcpwm_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .gpio_level(gpio), .port1_pin_q(pins),
    .port1_pwm_sel_q(sel));
  fcpwm_port_model i_load (.aclk(aclk), .drive_pattern(pattern), .pin_level(pins),
    .count_clr(clr), .gpio_level(gpio), .hi_cnt(hi));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp; bready <= 1'b0; break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata; r = rresp; rready <= 1'b0; break;
      end
    end
  endtask
  // counts pin high time over one whole period of 512 clocks (prescaler 1)
  task automatic measure(input logic [49:0] exp);
    repeat (4) @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (512) @(posedge aclk);
    #1;
    for (int c = 0; c < FCPWM_NCH; c++) check({22'h0, hi[c]}, {22'h0, exp[10*c+:10]});
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    check({27'h0, pins}, {27'h0, pattern});
    check({27'h0, sel}, 32'h0);
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].s, rows[i].d, rsp);
      check({30'h0, rsp}, {30'h0, rows[i].br});
      axi_rd(rows[i].a, rd, rsp);
      check(rd, rows[i].rd);
      check({30'h0, rsp}, {30'h0, rows[i].rr});
    end
    $display("register rows done");
    // prescaler 1 doubles every count: a full period is 512 clocks
    axi_wr(FCPWM_OFS_PRESC, 4'hf, 32'h01, rsp);
    axi_wr(FCPWM_OFS_DUTY0, 4'hf, 32'h40, rsp);
    axi_wr(8'h10, 4'hf, 32'h00, rsp);
    axi_wr(8'h14, 4'hf, 32'hff, rsp);
    axi_wr(8'h18, 4'hf, 32'h80, rsp);
    axi_wr(FCPWM_OFS_DUTY4, 4'hf, 32'h10, rsp);
    axi_wr(FCPWM_OFS_CTRL2, 4'hf, 32'h05, rsp);
    axi_wr(FCPWM_OFS_CTRL1, 4'hf, 32'hff, rsp);
    measure({10'd32, 10'd256, 10'd510, 10'd0, 10'd128});
    check({27'h0, sel}, 32'h1f);
    $display("all channels running done");
    // ch0 pin released to gpio, ch1 and ch4 stopped with pins still selected
    axi_wr(FCPWM_OFS_CTRL1, 4'hf, 32'hf9, rsp);
    axi_wr(FCPWM_OFS_CTRL2, 4'hf, 32'h04, rsp);
    measure({10'd0, 10'd256, 10'd510, 10'd0, 10'd512});
    check({27'h0, sel}, 32'h1e);
    $display("mixed enables done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(FCPWM_OFS_CTRL1, rd, rsp);
    check(rd, 32'h00);
    check({27'h0, sel}, 32'h0);
    $display("mid run reset done");
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
